// ### rtl/burst_order_gen.sv
// Burst beat address generator for wrapping and non-wrapping orders
`timescale 1ns/10ps
module burst_order_gen
	import mode_info_pkg::*;
(
	input wire logic [9:0] start_col_i,
	input wire logic [4:0] beat_i,
	input wire logic [2:0] burst_length_i,
	input wire logic burst_type_i,
	input wire logic wrap_control_i,
	output logic [9:0] col_o
);
	import mode_info_pkg::*;

	// Start column with the lsb forced low, never sent on the bus [RULE12]
	wire [9:0] even_col = {start_col_i[9:1], 1'b0};
	// Offset field mask per length [RULE13]
	wire [3:0] len_mask = (burst_length_i == BURST_LEN16) ? 4'hf :
		(burst_length_i == BURST_LEN8) ? 4'h7 : 4'h3;
	wire [3:0] beat4 = beat_i[3:0];
	// Sequential offset wraps modulo the length [RULE14] [RULE15]
	wire [3:0] seq_off = (even_col[3:0] + beat4) & len_mask;
	// Interleaved offset is start xor beat [RULE16]
	wire [3:0] int_off = (even_col[3:0] ^ beat4) & len_mask;
	wire [3:0] wrap_off = burst_type_i ? int_off : seq_off;
	// Non-wrapping length 4 simply counts up from y [RULE18]
	wire [9:0] nowrap_col = even_col + {6'h00, beat4};
	assign col_o = wrap_control_i ? nowrap_col : ((even_col & ~{6'h00, len_mask}) |
		{6'h00, wrap_off});
endmodule : burst_order_gen

// ### rtl/mode_info_pkg.sv
// Package: mode register map, field layouts, reset values and burst encodings
package mode_info_pkg;

	// Register addresses on the mode register command
	localparam logic [7:0] ADDR_INFO = 8'h00;
	localparam logic [7:0] ADDR_FEATURE = 8'h01;

	// Information register field positions
	localparam int INFO_AUTO_INIT_BIT = 0;
	localparam int INFO_CLASS_BIT = 1;
	localparam int INFO_DATA_INVALID_BIT = 2;
	localparam int INFO_SELFTEST_LO = 3;

	// Self-test result encodings
	localparam logic [1:0] SELFTEST_NONE = 2'h0;
	localparam logic [1:0] SELFTEST_SUPPLY = 2'h1;
	localparam logic [1:0] SELFTEST_GROUND = 2'h2;
	localparam logic [1:0] SELFTEST_PASS = 2'h3;

	// Burst length encodings
	localparam logic [2:0] BURST_LEN4 = 3'h2;
	localparam logic [2:0] BURST_LEN8 = 3'h3;
	localparam logic [2:0] BURST_LEN16 = 3'h4;

	// Write recovery encodings and offset from code to cycles
	localparam logic [2:0] WRITE_REC_MIN = 3'h1;
	localparam logic [2:0] WRITE_REC_MAX = 3'h6;
	localparam logic [3:0] WRITE_REC_OFFSET = 4'h2;

	// Feature register reset value: wr code 001, wrap, sequential, length 4
	localparam logic [7:0] FEATURE_RESET = 8'h22;

	// Calibration command code written to the calibration register
	localparam logic [7:0] ADDR_CALIBRATION = 8'h0a;
	localparam logic [7:0] CAL_INIT_CODE = 8'hff;

	// Auto-initialization duration in clock cycles
	localparam int AUTO_INIT_CYCLES = 16;

	// Decoded feature fields
	typedef struct packed {
		logic [2:0] write_recovery_cycles;
		logic wrap_control;
		logic burst_type;
		logic [2:0] burst_length;
	} feature_t;

	// Mode register command from the command decoder
	typedef struct packed {
		logic write_en;
		logic read_en;
		logic [7:0] addr;
		logic [7:0] data;
	} mode_cmd_t;

endpackage : mode_info_pkg

// ### rtl/mode_info_regs.sv
// Device information and feature mode registers with burst column sequencing
`timescale 1ns/10ps
//
// What this block does; RULE17 and RULE19 are left to the controller
// RULE1: Info bit0 high while auto-init runs
// RULE2: Info bits 1 and 2 read zero
// RULE3: Info bits 4:3 give impedance self-test
// RULE4: Self-test bits update on init calibration
// RULE5: Bad self-test: factory trim, ignore calibration
// RULE6: Pin tied to supply reports 01
// RULE7: Result 11 means resistor merely detected
// RULE8: Feature bits 2:0 choose burst length
// RULE9: Bit3 burst type, bit4 wrap control
// RULE10: Bits 7:5 set write recovery 3..8
// RULE11: Auto-precharge starts after recovery count
// RULE12: Column lsb is always zero
// RULE13: Start offset width follows burst length
// RULE14: Wrapping length 4 order by bit1
// RULE15: Sequential wrap increments modulo length
// RULE16: Interleaved wrap uses start xor beat
// RULE17: Controller avoids illegal burst combinations
// RULE18: Non-wrap length 4 counts up
// RULE19: Controller avoids page boundary starts
// RULE20: Mode read and write commands access registers
// RULE21: Reserved bits read as zero
// RULE22: Unreadable registers give data, strobe toggles
// RULE23: Writes to read-only register ignored
// RULE24: Feature register resets to defaults
module mode_info_regs
	import mode_info_pkg::*;
#(
	parameter int INIT_CYCLES = AUTO_INIT_CYCLES
)
(
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	input wire mode_info_pkg::mode_cmd_t CMD_I,
	input wire logic CAL_SUPPLY_TIE_I,
	input wire logic CAL_GROUND_SHORT_I,
	input wire logic WRITE_AP_I,
	input wire logic BURST_START_I,
	input wire logic [9:0] BURST_COL_I,
	output logic READ_VALID_O,
	output logic [7:0] READ_DATA_O,
	output logic STROBE_TOGGLE_O,
	output logic [7:0] FEATURE_O,
	output logic FACTORY_TRIM_O,
	output logic CAL_START_O,
	output logic PRECHARGE_O,
	output logic BURST_VALID_O,
	output logic [9:0] BURST_ADDR_O
);
	import mode_info_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for the calibration pin sense inputs

	logic [1:0] sup_sync_ff; // Supply tie sense, two stages
	logic [1:0] gnd_sync_ff; // Ground short sense, two stages

	// Only the second stage, bit 1, is read by logic; bit 0 may still be settling
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			sup_sync_ff <= 2'h0;
			gnd_sync_ff <= 2'h0;
		end
		else
		begin
			sup_sync_ff <= {sup_sync_ff[0], CAL_SUPPLY_TIE_I};
			gnd_sync_ff <= {gnd_sync_ff[0], CAL_GROUND_SHORT_I};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Auto-initialization tracking

	logic [15:0] init_cnt_ff; // Cycles left of auto-initialization
	logic init_busy_ff; // High while initialization runs
	wire init_done = (init_cnt_ff == 16'h0001);

	// Count down after reset release, then drop busy [RULE1]
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			init_cnt_ff <= 16'(INIT_CYCLES);
			init_busy_ff <= 1'b1;
		end
		else if (init_busy_ff)
		begin
			init_cnt_ff <= init_cnt_ff - 16'h0001;
			if (init_done)
				init_busy_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command decode

	wire wr_feature = CMD_I.write_en && (CMD_I.addr == ADDR_FEATURE);
	wire wr_cal_init = CMD_I.write_en && (CMD_I.addr == ADDR_CALIBRATION) &&
		(CMD_I.data == CAL_INIT_CODE);
	wire rd_info = CMD_I.read_en && (CMD_I.addr == ADDR_INFO);
	// A write to the info address matches nothing, so it changes nothing [RULE23]

	////////////////////////////////////////////////////////////////////////////////
	// Feature register

	feature_t feature_ff; // Burst and write recovery controls
	feature_t nxt_feature;
	assign nxt_feature = feature_t'(CMD_I.data);

	// Reset to defaults, load on a mode write [RULE24] [RULE20] [RULE8] [RULE9] [RULE10]
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
			feature_ff <= feature_t'(FEATURE_RESET);
		else if (wr_feature)
			feature_ff <= nxt_feature;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Impedance self-test result

	logic [1:0] impedance_selftest_result_ff; // Not supported until first init cal
	logic factory_trim_ff; // Fallback to trimmed driver impedance
	logic cal_start_ff; // Pulse to launch calibration
	// Supply tie reported as 01 first; 11 only says a resistor was seen [RULE6] [RULE7]
	wire [1:0] nxt_selftest = sup_sync_ff[1] ? SELFTEST_SUPPLY :
		gnd_sync_ff[1] ? SELFTEST_GROUND : SELFTEST_PASS;
	wire bad_pin = (nxt_selftest == SELFTEST_SUPPLY) || (nxt_selftest == SELFTEST_GROUND);

	// Result only changes on init calibration; once bad, calibration is dropped [RULE4] [RULE5]
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			impedance_selftest_result_ff <= SELFTEST_NONE;
			factory_trim_ff <= 1'b0;
			cal_start_ff <= 1'b0;
		end
		else
		begin
			cal_start_ff <= 1'b0;
			if (wr_cal_init && !factory_trim_ff)
			begin
				impedance_selftest_result_ff <= nxt_selftest;
				factory_trim_ff <= bad_pin;
				cal_start_ff <= !bad_pin;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode register read answer

	// Reserved and fixed bits return zero [RULE2] [RULE21] [RULE3]
	wire [7:0] info_word = {3'h0, impedance_selftest_result_ff, 1'b0, 1'b0, init_busy_ff};
	// Other addresses return zero data but still strobe [RULE22]
	wire [7:0] nxt_read = rd_info ? info_word : 8'h00;

	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			READ_VALID_O <= 1'b0;
			READ_DATA_O <= 8'h00;
			STROBE_TOGGLE_O <= 1'b0;
		end
		else
		begin
			READ_VALID_O <= CMD_I.read_en; // [RULE20]
			STROBE_TOGGLE_O <= CMD_I.read_en; // [RULE22]
			READ_DATA_O <= nxt_read;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Burst sequencer

	logic [4:0] beat_ff; // Current beat index
	logic burst_on_ff; // Burst in progress
	logic ap_ff; // Burst carries auto-precharge
	logic [9:0] col_ff; // Latched start column
	logic [3:0] rec_cnt_ff; // Write recovery countdown
	wire [9:0] beat_col;
	wire [4:0] last_beat = (feature_ff.burst_length == BURST_LEN16) ? 5'h0f :
		(feature_ff.burst_length == BURST_LEN8) ? 5'h07 : 5'h03;
	wire burst_end = burst_on_ff && (beat_ff == last_beat);
	// Recovery cycles are the code plus two [RULE10] [RULE11]
	wire [3:0] rec_cycles = {1'b0, feature_ff.write_recovery_cycles} + WRITE_REC_OFFSET;

	burst_order_gen u_order (
		.start_col_i(col_ff),
		.beat_i(beat_ff),
		.burst_length_i(feature_ff.burst_length),
		.burst_type_i(feature_ff.burst_type),
		.wrap_control_i(feature_ff.wrap_control),
		.col_o(beat_col)
	);

	// Walk the beats; start is ignored while a burst runs
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			beat_ff <= 5'h00;
			burst_on_ff <= 1'b0;
			ap_ff <= 1'b0;
			col_ff <= 10'h000;
		end
		else if (BURST_START_I && !burst_on_ff)
		begin
			burst_on_ff <= 1'b1;
			beat_ff <= 5'h00;
			ap_ff <= WRITE_AP_I;
			col_ff <= BURST_COL_I; // [RULE12]
		end
		else if (burst_on_ff)
		begin
			beat_ff <= beat_ff + 5'h01;
			if (burst_end)
				burst_on_ff <= 1'b0;
		end
	end

	// Precharge fires the programmed cycle count after the last beat [RULE11]
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			rec_cnt_ff <= 4'h0;
			PRECHARGE_O <= 1'b0;
		end
		else
		begin
			PRECHARGE_O <= (rec_cnt_ff == 4'h1);
			if (burst_end && ap_ff)
				rec_cnt_ff <= rec_cycles;
			else if (rec_cnt_ff != 4'h0)
				rec_cnt_ff <= rec_cnt_ff - 4'h1;
		end
	end

	// Registered outputs
	always_ff @(posedge REF_CLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			BURST_VALID_O <= 1'b0;
			BURST_ADDR_O <= 10'h000;
			FEATURE_O <= FEATURE_RESET;
			FACTORY_TRIM_O <= 1'b0;
			CAL_START_O <= 1'b0;
		end
		else
		begin
			BURST_VALID_O <= burst_on_ff;
			BURST_ADDR_O <= beat_col; // [RULE14] [RULE15] [RULE16] [RULE18]
			FEATURE_O <= feature_ff;
			FACTORY_TRIM_O <= factory_trim_ff;
			CAL_START_O <= cal_start_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	sequence s_ap_end;
		burst_end && ap_ff;
	endsequence

	a_info_reserved_zero: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE21]
		$past(rd_info) |-> READ_DATA_O[7:5] == 3'h0 && READ_DATA_O[2:1] == 2'h0)
		else $error("info reserved bits not zero");

	a_busy_reported: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE1]
		rd_info |=> READ_DATA_O[0] == $past(init_busy_ff))
		else $error("auto init status wrong");

	a_selftest_hold: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE4]
		!wr_cal_init |=> $stable(impedance_selftest_result_ff))
		else $error("self test changed without init cal");

	a_bad_ignores_cal: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE5]
		factory_trim_ff |=> !cal_start_ff && factory_trim_ff)
		else $error("calibration accepted after bad pin");

	a_feature_loads: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE20]
		wr_feature |=> feature_ff == $past(CMD_I.data))
		else $error("feature write lost");

	a_strobe_on_read: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE22]
		CMD_I.read_en |=> STROBE_TOGGLE_O && READ_VALID_O)
		else $error("no strobe on read");

	a_precharge_time: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE11]
		s_ap_end |=> (rec_cnt_ff == $past(rec_cycles)) ##1 (rec_cnt_ff >= 4'h2))
		else $error("recovery count wrong");

	a_col_lsb_zero: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE12]
		burst_on_ff |-> beat_col[0] == beat_ff[0])
		else $error("column lsb not implied zero");

	a_burst4_wrap: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I) // [RULE14]
		burst_on_ff && !feature_ff.wrap_control && feature_ff.burst_length == BURST_LEN4
		|-> beat_col[1:0] == ({col_ff[1], 1'b0} ^ beat_ff[1:0]))
		else $error("length 4 wrap order wrong");

endmodule : mode_info_regs

// ### testbench/host_ctrl_model.sv
// Host controller model that issues mode register read and write commands
`timescale 1ns/10ps
module host_ctrl_model
(
	input wire logic clk_i,
	output mode_info_pkg::mode_cmd_t cmd_o
);
	import mode_info_pkg::*;

	// Idle bus: both strobes low from time zero
	initial cmd_o = '0;

	// One-cycle command launched just after a rising edge
	// Idle address and data are inverted so that stale values cannot pass as a match
	task automatic issue(input logic wr, input logic [7:0] addr, input logic [7:0] data);
		@(posedge clk_i);
		#1;
		cmd_o = {wr, !wr, addr, data};
		@(posedge clk_i);
		#1;
		cmd_o = {1'b0, 1'b0, ~addr, ~data};
	endtask : issue
endmodule : host_ctrl_model

// ### testbench/sdram_info_feature_burst_order_tb.sv
// Self-checking bench for the information and feature registers and burst order
`timescale 1ns/10ps
module sdram_info_feature_burst_order_tb;
	import mode_info_pkg::*;

	localparam int INIT_N = 4; // Short auto-init so the run stays brief
	logic clk, rst_n, sup_tie, gnd_short, wr_ap, b_start, rd_valid, strobe;
	logic trim, cal_start, prech, b_valid;
	logic [7:0] rd_data, feature;
	logic [9:0] b_col, b_addr;
	mode_cmd_t cmd; // Driven by the host model
	int n_errors = 0;
	int tests_run = 0;

	mode_info_regs #(.INIT_CYCLES(INIT_N)) dut_u (.REF_CLK_I(clk), .RST_N_I(rst_n),
		.CMD_I(cmd), .CAL_SUPPLY_TIE_I(sup_tie), .CAL_GROUND_SHORT_I(gnd_short),
		.WRITE_AP_I(wr_ap), .BURST_START_I(b_start), .BURST_COL_I(b_col),
		.READ_VALID_O(rd_valid), .READ_DATA_O(rd_data), .STROBE_TOGGLE_O(strobe),
		.FEATURE_O(feature), .FACTORY_TRIM_O(trim), .CAL_START_O(cal_start),
		.PRECHARGE_O(prech), .BURST_VALID_O(b_valid), .BURST_ADDR_O(b_addr));

	host_ctrl_model host_u (.clk_i(clk), .cmd_o(cmd));

	////////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// Single comparison point; case inequality so an unknown never matches
	task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Advance n edges, then step past them so registered outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic do_reset();
		rst_n = 1'b0;
		tick(4);
		rst_n = 1'b1;
	endtask : do_reset

	// Read one register; answer and strobe stand in the cycle after the read
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		host_u.issue(1'b0, addr, 8'h00);
		chk("read valid", rd_valid, 1'b1);
		chk("read strobe", strobe, 1'b1);
		chk("read data", rd_data, exp);
	endtask : rd

	////////////////////////////////////////////////////////////////////////////
	// Defaults, busy flag, read-only write and write-only read
	task automatic test_init();
		chk("feature reset", feature, FEATURE_RESET);
		rd(ADDR_INFO, 8'h01);
		tick(INIT_N);
		rd(ADDR_INFO, 8'h00);
		host_u.issue(1'b1, ADDR_INFO, 8'hff);
		rd(ADDR_INFO, 8'h00);
		rd(ADDR_FEATURE, 8'h00);
	endtask : test_init

	// Self-test outcome per pin state; a faulty pin locks out later calibration
	task automatic test_cal(input logic sup, input logic gnd, input logic [1:0] res);
		do_reset();
		sup_tie = sup;
		gnd_short = gnd;
		tick(INIT_N + 2);
		host_u.issue(1'b1, ADDR_CALIBRATION, CAL_INIT_CODE);
		tick(1);
		chk("trim", trim, res != SELFTEST_PASS);
		chk("cal start", cal_start, res == SELFTEST_PASS);
		rd(ADDR_INFO, {3'h0, res, 3'h0});
		if (res != SELFTEST_PASS)
		begin
			sup_tie = 1'b0;
			gnd_short = 1'b0;
			tick(3);
			host_u.issue(1'b1, ADDR_CALIBRATION, CAL_INIT_CODE);
			tick(1);
			chk("ignored cal", {cal_start, trim}, 2'h1);
			rd(ADDR_INFO, {3'h0, res, 3'h0});
		end
	endtask : test_cal

	// Program the feature word, run one auto-precharge write burst, check order
	task automatic test_burst(input logic [7:0] feat, input logic [9:0] col);
		int n;
		int k;
		logic [9:0] s;
		logic [9:0] m;
		logic [9:0] e;
		host_u.issue(1'b1, ADDR_FEATURE, feat);
		tick(1);
		chk("feature", feature, feat);
		n = (feat[2:0] == BURST_LEN16) ? 16 : (feat[2:0] == BURST_LEN8) ? 8 : 4;
		s = {col[9:1], 1'b0};
		m = 10'(n - 1);
		b_col = col;
		wr_ap = 1'b1;
		b_start = 1'b1;
		tick(1);
		b_start = 1'b0;
		for (k = 0; k < n; k++)
		begin
			tick(1);
			if (feat[4])
				e = s + 10'(k);
			else if (feat[3])
				e = (s & ~m) | ((s ^ 10'(k)) & m);
			else
				e = (s & ~m) | ((s + 10'(k)) & m);
			chk("beat valid", b_valid, 1'b1);
			chk("beat addr", b_addr, e);
		end
		k = 0;
		while (prech !== 1'b1 && k < 20)
		begin
			tick(1);
			k++;
		end
		// Counted from the last beat on the outputs: exactly the programmed cycle count
		chk("precharge delay", 10'(k), 10'(feat[7:5]) + 10'(WRITE_REC_OFFSET));
		chk("burst end", b_valid, 1'b0);
	endtask : test_burst

	// A burst without auto-precharge must leave the precharge pulse quiet
	task automatic test_no_ap();
		int k;
		int seen;
		seen = 0;
		wr_ap = 1'b0;
		b_start = 1'b1;
		tick(1);
		b_start = 1'b0;
		for (k = 0; k < 16; k++)
		begin
			tick(1);
			if (prech === 1'b1)
				seen++;
		end
		chk("no precharge", 10'(seen), 10'h000);
	endtask : test_no_ap

	////////////////////////////////////////////////////////////////////////////
	task automatic report_and_stop();
		if (n_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	// Main sequence; only legal burst settings and columns are used
	initial
	begin
		rst_n = 1'b0;
		sup_tie = 1'b0;
		gnd_short = 1'b0;
		wr_ap = 1'b0;
		b_start = 1'b0;
		b_col = 10'h000;
		do_reset();
		test_init();
		test_cal(1'b0, 1'b0, SELFTEST_PASS);
		test_cal(1'b1, 1'b1, SELFTEST_SUPPLY);
		test_cal(1'b0, 1'b1, SELFTEST_GROUND);
		test_burst(8'h22, 10'h002);
		test_burst(8'h2a, 10'h103);
		test_burst(8'h43, 10'h006);
		test_burst(8'h6b, 10'h002);
		test_burst(8'h84, 10'h01b);
		test_burst(8'ha2, 10'h1fc);
		test_burst(8'hd2, 10'h0f6);
		test_no_ap();
		report_and_stop();
	end

	// Watchdog: the sequence needs well under 1000 cycles
	initial
	begin
		#(50 * 3000);
		n_errors++;
		report_and_stop();
	end
endmodule : sdram_info_feature_burst_order_tb
